// ---- src/vmx_params.svh ----
// Register map, field layout and timing constants of the video matrix write port
`ifndef VMX_PARAMS_SVH
`define VMX_PARAMS_SVH

`define VMX_NUM_OUT      9
`define VMX_NUM_IN       12
`define VMX_SEL_W        5
`define VMX_GAIN_W       2

`define VMX_SLAVE_ADDR   8'h06
`define VMX_ADDR_SEL_BIT 8'h80

`define VMX_OUT_FIRST    8'h01
`define VMX_OUT_LAST     8'h09
`define VMX_CLAMP_LO     8'h1D
`define VMX_CLAMP_HI     8'h1E

`define VMX_EN_BIT       7
`define VMX_GAIN_HI      6
`define VMX_GAIN_LO      5
`define VMX_SEL_HI       4
`define VMX_SEL_LO       0
`define VMX_REG_RESET    8'h00

`define VMX_CLK_NS       25
`define VMX_CLK_HZ       40000000
`define VMX_AMP_NS       300
`define VMX_AMP_CYC      (`VMX_AMP_NS / `VMX_CLK_NS)
`define VMX_SCL_HZ       100000
`define VMX_SCL_QTR      (`VMX_CLK_HZ / (4 * `VMX_SCL_HZ))
`define VMX_DIV_W        12

`endif

// ---- src/vmx_pkg.sv ----
// Types shared by both ends of the video matrix write port
`include "vmx_params.svh"

package vmx_pkg;

	typedef enum logic [3:0] {
		VMX_D_IDLE = 4'h1,
		VMX_D_RECV = 4'h2,
		VMX_D_ACK  = 4'h4,
		VMX_D_SKIP = 4'h8
	} vmx_dev_st_t;

	typedef enum logic [3:0] {
		VMX_M_IDLE  = 4'h1,
		VMX_M_START = 4'h2,
		VMX_M_BIT   = 4'h4,
		VMX_M_STOP  = 4'h8
	} vmx_mst_st_t;

	typedef struct packed {
		vmx_dev_st_t                                 st;
		logic [1:0]                                  scl_s;
		logic [1:0]                                  sda_s;
		logic [1:0]                                  asel_s;
		logic                                        scl_p;
		logic                                        sda_p;
		logic [3:0]                                  bitcnt;
		logic [7:0]                                  shift;
		logic [1:0]                                  bytecnt;
		logic [7:0]                                  ptr;
		logic                                        sda_oe;
		logic [`VMX_NUM_OUT-1:0][7:0]                outreg;
		logic [`VMX_NUM_IN-1:0]                      clamp;
		logic [`VMX_NUM_OUT-1:0][3:0]                amp_cnt;
		logic [`VMX_NUM_OUT-1:0]                     amp_on;
		logic [`VMX_NUM_OUT-1:0][`VMX_SEL_W-1:0]     sel_o;
		logic [`VMX_NUM_OUT-1:0]                     ref_low;
	} vmx_dev_state_t;

	typedef struct packed {
		vmx_mst_st_t               st;
		logic [`VMX_DIV_W-1:0]     div;
		logic [2:0]                q;
		logic [3:0]                bitn;
		logic [1:0]                byten;
		logic [23:0]               sh;
		logic                      scl_oe;
		logic                      sda_oe;
		logic [1:0]                scl_s;
		logic [1:0]                sda_s;
		logic                      ack;
		logic                      ready;
		logic                      done;
		logic                      nack;
	} vmx_mst_state_t;

endpackage

// ---- src/vmx_i2c_if.sv ----
// Two-wire bus between the write master and the matrix device, with open-drain resolution
interface vmx_i2c_if;
	logic m_scl_out;
	logic m_scl_oe;
	logic m_sda_out;
	logic m_sda_oe;
	logic d_sda_out;
	logic d_sda_oe;
	logic scl;
	logic sda;

	// Pull-ups keep both lines high unless a party drives low
	assign scl = ~(m_scl_oe & ~m_scl_out);
	assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

	modport master (
		output m_scl_out,
		output m_scl_oe,
		output m_sda_out,
		output m_sda_oe,
		input  scl,
		input  sda
	);

	modport dev (
		output d_sda_out,
		output d_sda_oe,
		input  scl,
		input  sda
	);
endinterface

// ---- src/vmx_i2c_master.sv ----
// Bus master end: sends address, pointer and data bytes as one register write
`include "vmx_params.svh"

module vmx_i2c_master #(
	parameter int QTR = `VMX_SCL_QTR
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	vmx_i2c_if.master        bus,
	input  wire logic        wr_valid_in,
	input  wire logic [7:0]  wr_slave_in,
	input  wire logic [7:0]  wr_ptr_in,
	input  wire logic [7:0]  wr_data_in,
	output logic             wr_ready_out,
	output logic             wr_done_out,
	output logic             wr_nack_out
);

	vmx_pkg::vmx_mst_state_t s;
	vmx_pkg::vmx_mst_state_t n;
	logic                    tick;

	always_comb begin
		n = s;
		n.scl_s = {s.scl_s[0], bus.scl};
		n.sda_s = {s.sda_s[0], bus.sda};
		n.done = 1'b0;
		tick = (s.div == `VMX_DIV_W'(QTR - 1));
		n.div = (tick || s.st == vmx_pkg::VMX_M_IDLE) ? '0 : s.div + `VMX_DIV_W'(1);
		case (s.st)
			vmx_pkg::VMX_M_IDLE: begin
				n.ready = 1'b1;
				// Start only on an idle bus with both lines released
				if (wr_valid_in && s.ready && s.scl_s[1] && s.sda_s[1]) begin
					n.sh = {wr_slave_in, wr_ptr_in, wr_data_in};
					n.st = vmx_pkg::VMX_M_START;
					n.q = 3'h0;
					n.ready = 1'b0;
					n.nack = 1'b0;
				end
			end
			vmx_pkg::VMX_M_START: begin
				if (tick) begin
					n.q = s.q + 3'h1;
					if (s.q == 3'h0) begin
						n.sda_oe = 1'b1;
					end else begin
						n.scl_oe = 1'b1;
						n.st = vmx_pkg::VMX_M_BIT;
						n.q = 3'h0;
						n.bitn = 4'h0;
						n.byten = 2'h0;
					end
				end
			end
			vmx_pkg::VMX_M_BIT: begin
				if (tick) begin
					n.q = s.q + 3'h1;
					case (s.q)
						3'h0: n.sda_oe = (s.bitn == 4'h8) ? 1'b0 : ~s.sh[23];
						3'h1: n.scl_oe = 1'b0;
						3'h2: if (s.bitn == 4'h8) n.ack = ~s.sda_s[1];
						default: begin
							n.scl_oe = 1'b1;
							n.q = 3'h0;
							if (s.bitn == 4'h8) begin
								n.bitn = 4'h0;
								if (!s.ack) begin
									n.nack = 1'b1;
									n.st = vmx_pkg::VMX_M_STOP;
								end else if (s.byten == 2'h2) begin
									n.st = vmx_pkg::VMX_M_STOP;
								end else begin
									n.byten = s.byten + 2'h1;
								end
							end else begin
								n.sh = {s.sh[22:0], 1'b0};
								n.bitn = s.bitn + 4'h1;
							end
						end
					endcase
				end
			end
			vmx_pkg::VMX_M_STOP: begin
				// The tail quarters keep the bus free long enough before another start
				if (tick) begin
					n.q = s.q + 3'h1;
					case (s.q)
						3'h0: n.sda_oe = 1'b1;
						3'h1: n.scl_oe = 1'b0;
						3'h2: n.sda_oe = 1'b0;
						3'h7: begin
							n.st = vmx_pkg::VMX_M_IDLE;
							n.done = 1'b1;
						end
						default: n.q = s.q + 3'h1;
					endcase
				end
			end
			default: n.st = vmx_pkg::VMX_M_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.st <= vmx_pkg::VMX_M_IDLE;
		end else begin
			s <= n;
		end
	end

	assign bus.m_scl_out = 1'b0;
	assign bus.m_sda_out = 1'b0;
	assign bus.m_scl_oe = s.scl_oe;
	assign bus.m_sda_oe = s.sda_oe;
	assign wr_ready_out = s.ready;
	assign wr_done_out = s.done;
	assign wr_nack_out = s.nack;

endmodule

// ---- src/vmx_i2c_slave.sv ----
// Device end: write-only two-wire slave holding the crosspoint output and clamp settings
`include "vmx_params.svh"

module vmx_i2c_slave #(
	parameter int AMP_CYC = `VMX_AMP_CYC
) (
	input  wire logic                                   clk_sys_in,
	input  wire logic                                   rst_n_in,
	input  wire logic                                   addr_sel_in,
	vmx_i2c_if.dev                                      bus,
	output logic [`VMX_NUM_OUT-1:0]                     out_enable_out,
	output logic [`VMX_NUM_OUT*`VMX_GAIN_W-1:0]         out_gain_out,
	output logic [`VMX_NUM_OUT*`VMX_SEL_W-1:0]          out_route_out,
	output logic [`VMX_NUM_OUT-1:0]                     amp_active_out,
	output logic [`VMX_NUM_OUT-1:0]                     amp_ref_low_out,
	output logic [`VMX_NUM_IN-1:0]                      in_clamp_out
);

	vmx_pkg::vmx_dev_state_t s;
	vmx_pkg::vmx_dev_state_t n;
	logic                    scl;
	logic                    sda;
	logic                    rise;
	logic                    fall;
	logic                    start_c;
	logic                    stop_c;
	logic [7:0]              my_addr;

	always_comb begin
		n = s;
		// First stages feed only the second stages
		n.scl_s = {s.scl_s[0], bus.scl};
		n.sda_s = {s.sda_s[0], bus.sda};
		n.asel_s = {s.asel_s[0], addr_sel_in};
		n.scl_p = s.scl_s[1];
		n.sda_p = s.sda_s[1];
		scl = s.scl_s[1];
		sda = s.sda_s[1];
		rise = scl & ~s.scl_p;
		fall = ~scl & s.scl_p;
		start_c = scl & s.scl_p & s.sda_p & ~sda;
		stop_c = scl & s.scl_p & ~s.sda_p & sda;
		my_addr = s.asel_s[1] ? (`VMX_SLAVE_ADDR | `VMX_ADDR_SEL_BIT) : `VMX_SLAVE_ADDR;

		if (start_c) begin
			n.st = vmx_pkg::VMX_D_RECV;
			n.bitcnt = 4'h0;
			n.bytecnt = 2'h0;
			n.sda_oe = 1'b0;
		end else if (stop_c) begin
			n.st = vmx_pkg::VMX_D_IDLE;
			n.sda_oe = 1'b0;
		end else begin
			case (s.st)
				vmx_pkg::VMX_D_RECV: begin
					if (rise && s.bitcnt != 4'h8) begin
						n.shift = {s.shift[6:0], sda};
						n.bitcnt = s.bitcnt + 4'h1;
					end else if (fall && s.bitcnt == 4'h8) begin
						n.bitcnt = 4'h0;
						// The read flag is part of the match, so read requests go unanswered
						if (s.bytecnt == 2'h0 && s.shift != my_addr) begin
							n.st = vmx_pkg::VMX_D_SKIP;
						end else begin
							n.st = vmx_pkg::VMX_D_ACK;
							n.sda_oe = 1'b1;
							if (s.bytecnt == 2'h1) begin
								n.ptr = s.shift;
							end else if (s.bytecnt == 2'h2) begin
								// Further data bytes go to the following registers
								n.ptr = s.ptr + 8'h01;
								for (int i = 0; i < `VMX_NUM_OUT; i++) begin
									if (s.ptr == 8'(`VMX_OUT_FIRST + i)) begin
										n.outreg[i] = s.shift;
									end
								end
								if (s.ptr == `VMX_CLAMP_LO) begin
									n.clamp[7:0] = s.shift;
								end
								if (s.ptr == `VMX_CLAMP_HI) begin
									n.clamp[`VMX_NUM_IN-1:8] = s.shift[`VMX_NUM_IN-9:0];
								end
								// Any other pointer leaves every setting untouched
							end
							if (s.bytecnt != 2'h2) begin
								n.bytecnt = s.bytecnt + 2'h1;
							end
						end
					end
				end
				vmx_pkg::VMX_D_ACK: begin
					// Release only after SCL falls, so SDA is low across the whole high phase
					if (fall) begin
						n.sda_oe = 1'b0;
						n.st = vmx_pkg::VMX_D_RECV;
					end
				end
				vmx_pkg::VMX_D_SKIP: n.sda_oe = 1'b0;
				vmx_pkg::VMX_D_IDLE: n.sda_oe = 1'b0;
				default: n.st = vmx_pkg::VMX_D_IDLE;
			endcase
		end

		for (int i = 0; i < `VMX_NUM_OUT; i++) begin
			// Amplifier state trails the enable bit by a fixed settle time
			if (s.amp_on[i] != s.outreg[i][`VMX_EN_BIT]) begin
				if (s.amp_cnt[i] == 4'(AMP_CYC - 1)) begin
					n.amp_on[i] = s.outreg[i][`VMX_EN_BIT];
					n.amp_cnt[i] = 4'h0;
				end else begin
					n.amp_cnt[i] = s.amp_cnt[i] + 4'h1;
				end
			end else begin
				n.amp_cnt[i] = 4'h0;
			end
			// Power down also deselects the routed input
			n.sel_o[i] = s.outreg[i][`VMX_EN_BIT] ? s.outreg[i][`VMX_SEL_HI:`VMX_SEL_LO] : '0;
			n.ref_low[i] = s.outreg[i][`VMX_EN_BIT] && s.outreg[i][`VMX_SEL_HI:`VMX_SEL_LO] == '0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.st <= vmx_pkg::VMX_D_IDLE;
		end else begin
			s <= n;
		end
	end

	assign bus.d_sda_out = 1'b0;
	assign bus.d_sda_oe = s.sda_oe;
	assign amp_active_out = s.amp_on;
	assign amp_ref_low_out = s.ref_low;
	assign in_clamp_out = s.clamp;

	genvar g;
	generate
		for (g = 0; g < `VMX_NUM_OUT; g++) begin : g_out
			assign out_enable_out[g] = s.outreg[g][`VMX_EN_BIT];
			assign out_gain_out[g*`VMX_GAIN_W +: `VMX_GAIN_W] = s.outreg[g][`VMX_GAIN_HI:`VMX_GAIN_LO];
			assign out_route_out[g*`VMX_SEL_W +: `VMX_SEL_W] = s.sel_o[g];
		end
	endgenerate

endmodule

// ---- bench/vmx_link_monitor.sv ----
// Wire-level checker for the two-wire link between master end and device end
module vmx_link_monitor (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic m_sda_oe,
	input wire logic d_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic       d_oe_q;
	logic [3:0] rise_cnt_q;
	logic       start_w;
	logic       stop_w;

	assign start_w = scl_q & scl & sda_q & ~sda;
	assign stop_w  = scl_q & scl & ~sda_q & sda;

	// Counts clock rises since START or since the last ack ended
	always_ff @(posedge clk_sys_in) begin
		scl_q  <= scl;
		sda_q  <= sda;
		d_oe_q <= d_sda_oe;
		if (!rst_n_in || start_w || (d_oe_q && !d_sda_oe)) begin
			rise_cnt_q <= 4'h0;
		end else if (scl && !scl_q) begin
			rise_cnt_q <= rise_cnt_q + 4'h1;
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	a_start_from_idle: assert property ($rose(m_sda_oe) && scl |-> $past(sda) && $past(scl))
		else $error("start issued on a busy bus");
	a_ack_after_eight: assert property ($rose(d_sda_oe) |-> rise_cnt_q == 4'h8 && !scl)
		else $error("ack not after eighth bit with clock low");
	a_ack_in_slot: assert property (d_sda_oe |-> rise_cnt_q inside {4'h8, 4'h9})
		else $error("device drives data outside ack slot");
	a_ack_hold_high: assert property ($rose(scl) && d_sda_oe |-> d_sda_oe[*8])
		else $error("ack released during clock high");
	a_ack_release_low: assert property ($fell(d_sda_oe) |-> !scl)
		else $error("ack released while clock high");
	a_ack_bounded: assert property ($rose(d_sda_oe) |-> ##[8:40] $fell(d_sda_oe))
		else $error("ack length out of range");
	a_stop_clean: assert property (stop_w |-> !d_sda_oe)
		else $error("device drives data at stop");
	a_start_quiet: assert property (start_w |-> (!d_sda_oe)[*8])
		else $error("device drives data just after start");
endmodule

// ---- bench/test_video_matrix_i2c_write_port.sv ----
// Bench writing device registers through the master end and checking the device outputs
module test_video_matrix_i2c_write_port;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        addr_sel_in = 1'b0;
	logic        wr_valid_in = 1'b0;
	logic [7:0]  wr_slave_in = 8'h00;
	logic [7:0]  wr_ptr_in = 8'h00;
	logic [7:0]  wr_data_in = 8'h00;
	logic        wr_ready_out;
	logic        wr_done_out;
	logic        wr_nack_out;
	logic [8:0]  out_enable_out;
	logic [17:0] out_gain_out;
	logic [44:0] out_route_out;
	logic [8:0]  amp_active_out;
	logic [8:0]  amp_ref_low_out;
	logic [11:0] in_clamp_out;
	logic [7:0]  bad_ptr [5] = '{8'h00, 8'h0A, 8'h1C, 8'h1F, 8'hFF};
	logic [7:0]  bad_sa [3] = '{8'h07, 8'h86, 8'h0E};
	int          errors = 0;
	int          n_tests = 0;

	vmx_i2c_if vmx_i2c_if_i ();
	// Short quarter and amp delay keep the run brief; the quarter stays above the synchronizer depth, the amp delay equals it
	vmx_i2c_master #(.QTR(4)) vmx_i2c_master_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.bus(vmx_i2c_if_i), .wr_valid_in(wr_valid_in), .wr_slave_in(wr_slave_in), .wr_ptr_in(wr_ptr_in),
		.wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out), .wr_done_out(wr_done_out),
		.wr_nack_out(wr_nack_out));
	vmx_i2c_slave #(.AMP_CYC(2)) vmx_i2c_slave_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.addr_sel_in(addr_sel_in), .bus(vmx_i2c_if_i), .out_enable_out(out_enable_out),
		.out_gain_out(out_gain_out), .out_route_out(out_route_out), .amp_active_out(amp_active_out),
		.amp_ref_low_out(amp_ref_low_out), .in_clamp_out(in_clamp_out));
	vmx_link_monitor vmx_link_monitor_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.m_sda_oe(vmx_i2c_if_i.m_sda_oe), .d_sda_oe(vmx_i2c_if_i.d_sda_oe),
		.scl(vmx_i2c_if_i.scl), .sda(vmx_i2c_if_i.sda));

	always #12.5 clk_sys_in = ~clk_sys_in;

	task automatic print_verdict();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [44:0] seen, input logic [44:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] sa, input logic [7:0] pa, input logic [7:0] da);
		int n;
		n = 0;
		chk(45'(wr_ready_out), 45'h1);
		wr_slave_in <= sa;
		wr_ptr_in <= pa;
		wr_data_in <= da;
		wr_valid_in <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (wr_ready_out !== 1'b0 && n < 200);
		wr_valid_in <= 1'b0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (wr_done_out !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			errors++;
		end
		repeat (8) @(posedge clk_sys_in);
	endtask

	// Amplifier state is expected to have caught up with the enables by now
	task automatic expect_all(input logic [8:0] e, input logic [17:0] g, input logic [44:0] r,
		input logic [8:0] lo, input logic [11:0] c, input logic nk);
		chk(45'(out_enable_out), 45'(e));
		chk(45'(out_gain_out), 45'(g));
		chk(out_route_out, r);
		chk(45'(amp_active_out), 45'(e));
		chk(45'(amp_ref_low_out), 45'(lo));
		chk(45'(in_clamp_out), 45'(c));
		chk(45'(wr_nack_out), 45'(nk));
	endtask

	initial begin
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		expect_all(9'h0, 18'h0, 45'h0, 9'h0, 12'h0, 1'b0);
		wr(8'h06, 8'h02, 8'h85);
		expect_all(9'h002, 18'h0, 45'hA0, 9'h0, 12'h0, 1'b0);
		wr(8'h06, 8'h09, 8'hE0);
		expect_all(9'h102, 18'h30000, 45'hA0, 9'h100, 12'h0, 1'b0);
		wr(8'h06, 8'h01, 8'h1C);
		expect_all(9'h102, 18'h30000, 45'hA0, 9'h100, 12'h0, 1'b0);
		wr(8'h06, 8'h1D, 8'hA5);
		wr(8'h06, 8'h1E, 8'hFC);
		expect_all(9'h102, 18'h30000, 45'hA0, 9'h100, 12'hCA5, 1'b0);
		foreach (bad_ptr[i]) begin
			wr(8'h06, bad_ptr[i], 8'hFF);
			expect_all(9'h102, 18'h30000, 45'hA0, 9'h100, 12'hCA5, 1'b0);
		end
		foreach (bad_sa[i]) begin
			wr(bad_sa[i], 8'h02, 8'h00);
			expect_all(9'h102, 18'h30000, 45'hA0, 9'h100, 12'hCA5, 1'b1);
		end
		addr_sel_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		wr(8'h86, 8'h02, 8'h00);
		expect_all(9'h100, 18'h30000, 45'h0, 9'h100, 12'hCA5, 1'b0);
		wr(8'h06, 8'h02, 8'hFF);
		expect_all(9'h100, 18'h30000, 45'h0, 9'h100, 12'hCA5, 1'b1);
		print_verdict();
	end

	initial begin
		#(25 * 30000);
		errors++;
		print_verdict();
	end
endmodule
